// *** hpsc_pkg.sv ***
package hpsc_pkg;
    // ==========================================
    // timing and current scale
    localparam int CLK_PERIOD_PS = 5000;
    localparam longint SETTLE_UNIT_PS = 64'd2000000000;
    localparam int SETTLE_UNIT_CYCLES = int'(SETTLE_UNIT_PS / CLK_PERIOD_PS);
    localparam int CURRENT_UNIT_MA = 2;

    // ==========================================
    // register offsets
    localparam logic [7:0] OFS_SELF_CURRENT = 8'h0e;
    localparam logic [7:0] OFS_BUS_CURRENT = 8'h0f;
    localparam logic [7:0] OFS_SETTLE = 8'h10;
    localparam logic [7:0] OFS_LANG_UPPER = 8'h11;
    localparam logic [7:0] OFS_LANG_LOWER = 8'h12;
    localparam logic [7:0] OFS_MAKER_LEN = 8'h13;
    localparam logic [7:0] OFS_ITEM_LEN = 8'h14;
    localparam logic [7:0] OFS_SERIAL_LEN = 8'h15;
    localparam logic [7:0] OFS_MAKER_TEXT = 8'h16;
    localparam logic [7:0] OFS_ITEM_TEXT = 8'h54;
    localparam logic [7:0] OFS_SERIAL_TEXT = 8'h92;
    localparam logic [7:0] OFS_TEXT_END = 8'hcf;

    // ==========================================
    // sizes and reset values
    localparam logic [7:0] TEXT_AREA_BYTES = 8'h3e;
    localparam int TEXT_MEM_DEPTH = 186;
    localparam logic [7:0] MAX_TEXT_CHARS = 8'h1f;
    localparam logic [7:0] RST_CURRENT = 8'h32;
    localparam logic [7:0] RST_OTHER = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ==========================================
    // string selectors
    localparam logic [1:0] SEL_MAKER = 2'h0;
    localparam logic [1:0] SEL_ITEM = 2'h1;
    localparam logic [1:0] SEL_SERIAL = 2'h2;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } hpsc_tx_state_t;

    typedef enum logic [1:0] {
        PW_IDLE = 2'b01,
        PW_WAIT = 2'b10
    } hpsc_pw_state_t;
endpackage

// *** hpsc_config_bank.sv ***
`timescale 1ns/100ps
module hpsc_config_bank #(
    parameter int UNIT_CYCLES = hpsc_pkg::SETTLE_UNIT_CYCLES,
    parameter logic [7:0] SETTLE_RESET = hpsc_pkg::RST_OTHER
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cfgWrEn,
    input wire logic cfgRdEn,
    input wire logic [7:0] cfgAddr,
    input wire logic [7:0] cfgWrData,
    output logic [7:0] cfgRdData,
    output logic cfgRdValid,
    output logic [8:0] selfCurrentMa,
    output logic [8:0] busCurrentMa,
    output logic [15:0] languageCode,
    input wire logic portPowerStart,
    output logic portPowerGood,
    output logic portPowerBusy,
    input wire logic strReq,
    input wire logic [1:0] strSel,
    output logic strValid,
    output logic [7:0] strByte,
    output logic strLast,
    output logic strDone,
    output logic strBusy
);
    // ==========================================
    // configuration registers
    logic [7:0] selfCur_ff, nxt_selfCur;
    logic [7:0] busCur_ff, nxt_busCur;
    logic [7:0] settle_ff, nxt_settle;
    logic [7:0] langUp_ff, nxt_langUp;
    logic [7:0] langLo_ff, nxt_langLo;
    logic [7:0] makerLen_ff, nxt_makerLen;
    logic [7:0] itemLen_ff, nxt_itemLen;
    logic [7:0] serialLen_ff, nxt_serialLen;
    logic [8:0] selfMa_ff, nxt_selfMa;
    logic [8:0] busMa_ff, nxt_busMa;
    logic [15:0] lang_ff, nxt_lang;
    logic [7:0] rdData_ff, nxt_rdData;
    logic rdValid_ff, nxt_rdValid;
    logic [7:0] textMem [hpsc_pkg::TEXT_MEM_DEPTH];
    logic inText;
    logic [7:0] wrLen;
    logic [7:0] textIdx;

    assign inText = (cfgAddr >= hpsc_pkg::OFS_MAKER_TEXT) && (cfgAddr <= hpsc_pkg::OFS_TEXT_END);
    assign textIdx = cfgAddr - hpsc_pkg::OFS_MAKER_TEXT;
    // lengths above the limit are held at the limit
    assign wrLen = (cfgWrData > hpsc_pkg::MAX_TEXT_CHARS) ? hpsc_pkg::MAX_TEXT_CHARS : cfgWrData;

    always_comb begin
        nxt_selfCur = selfCur_ff;
        nxt_busCur = busCur_ff;
        nxt_settle = settle_ff;
        nxt_langUp = langUp_ff;
        nxt_langLo = langLo_ff;
        nxt_makerLen = makerLen_ff;
        nxt_itemLen = itemLen_ff;
        nxt_serialLen = serialLen_ff;
        if (cfgWrEn) begin
            if (cfgAddr == hpsc_pkg::OFS_SELF_CURRENT) begin
                nxt_selfCur = cfgWrData;
            end else if (cfgAddr == hpsc_pkg::OFS_BUS_CURRENT) begin
                nxt_busCur = cfgWrData;
            end else if (cfgAddr == hpsc_pkg::OFS_SETTLE) begin
                nxt_settle = cfgWrData;
            end else if (cfgAddr == hpsc_pkg::OFS_LANG_UPPER) begin
                nxt_langUp = cfgWrData;
            end else if (cfgAddr == hpsc_pkg::OFS_LANG_LOWER) begin
                nxt_langLo = cfgWrData;
            end else if (cfgAddr == hpsc_pkg::OFS_MAKER_LEN) begin
                nxt_makerLen = wrLen;
            end else if (cfgAddr == hpsc_pkg::OFS_ITEM_LEN) begin
                nxt_itemLen = wrLen;
            end else if (cfgAddr == hpsc_pkg::OFS_SERIAL_LEN) begin
                nxt_serialLen = wrLen;
            end
        end
        // 2 mA per count
        nxt_selfMa = 9'(nxt_selfCur * hpsc_pkg::CURRENT_UNIT_MA);
        nxt_busMa = 9'(nxt_busCur * hpsc_pkg::CURRENT_UNIT_MA);
        nxt_lang = {nxt_langUp, nxt_langLo};
        nxt_rdValid = cfgRdEn;
        nxt_rdData = rdData_ff;
        if (cfgRdEn) begin
            if (cfgAddr == hpsc_pkg::OFS_SELF_CURRENT) begin
                nxt_rdData = selfCur_ff;
            end else if (cfgAddr == hpsc_pkg::OFS_BUS_CURRENT) begin
                nxt_rdData = busCur_ff;
            end else if (cfgAddr == hpsc_pkg::OFS_SETTLE) begin
                nxt_rdData = settle_ff;
            end else if (cfgAddr == hpsc_pkg::OFS_LANG_UPPER) begin
                nxt_rdData = langUp_ff;
            end else if (cfgAddr == hpsc_pkg::OFS_LANG_LOWER) begin
                nxt_rdData = langLo_ff;
            end else if (cfgAddr == hpsc_pkg::OFS_MAKER_LEN) begin
                nxt_rdData = makerLen_ff;
            end else if (cfgAddr == hpsc_pkg::OFS_ITEM_LEN) begin
                nxt_rdData = itemLen_ff;
            end else if (cfgAddr == hpsc_pkg::OFS_SERIAL_LEN) begin
                nxt_rdData = serialLen_ff;
            end else if (inText) begin
                nxt_rdData = textMem[textIdx];
            end else begin
                nxt_rdData = hpsc_pkg::READ_ZERO;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            selfCur_ff <= hpsc_pkg::RST_CURRENT;
            busCur_ff <= hpsc_pkg::RST_CURRENT;
            settle_ff <= SETTLE_RESET;
            langUp_ff <= hpsc_pkg::RST_OTHER;
            langLo_ff <= hpsc_pkg::RST_OTHER;
            makerLen_ff <= hpsc_pkg::RST_OTHER;
            itemLen_ff <= hpsc_pkg::RST_OTHER;
            serialLen_ff <= hpsc_pkg::RST_OTHER;
            selfMa_ff <= 9'(hpsc_pkg::RST_CURRENT * hpsc_pkg::CURRENT_UNIT_MA);
            busMa_ff <= 9'(hpsc_pkg::RST_CURRENT * hpsc_pkg::CURRENT_UNIT_MA);
            lang_ff <= {hpsc_pkg::RST_OTHER, hpsc_pkg::RST_OTHER};
            rdData_ff <= hpsc_pkg::READ_ZERO;
            rdValid_ff <= 1'b0;
        end else begin
            selfCur_ff <= nxt_selfCur;
            busCur_ff <= nxt_busCur;
            settle_ff <= nxt_settle;
            langUp_ff <= nxt_langUp;
            langLo_ff <= nxt_langLo;
            makerLen_ff <= nxt_makerLen;
            itemLen_ff <= nxt_itemLen;
            serialLen_ff <= nxt_serialLen;
            selfMa_ff <= nxt_selfMa;
            busMa_ff <= nxt_busMa;
            lang_ff <= nxt_lang;
            rdData_ff <= nxt_rdData;
            rdValid_ff <= nxt_rdValid;
        end
    end

    // ==========================================
    // string storage, byte per address
    always_ff @(posedge core_clk) begin
        if (cfgWrEn && inText) begin
            textMem[textIdx] <= cfgWrData;
        end
    end

    // ==========================================
    // port power settling timer
    localparam int TICK_W = $clog2(UNIT_CYCLES + 1);
    hpsc_pkg::hpsc_pw_state_t pwState_ff, nxt_pwState;
    logic [TICK_W-1:0] tick_ff, nxt_tick;
    logic [7:0] units_ff, nxt_units;
    logic good_ff, nxt_good;
    logic unitEnd;

    // one-cycle enable every 2 ms
    assign unitEnd = (tick_ff == TICK_W'(UNIT_CYCLES - 1));

    always_comb begin
        nxt_pwState = pwState_ff;
        nxt_tick = tick_ff;
        nxt_units = units_ff;
        nxt_good = good_ff;
        case (pwState_ff)
            hpsc_pkg::PW_IDLE: begin
                if (portPowerStart) begin
                    nxt_good = (settle_ff == 8'h00);
                    nxt_units = settle_ff;
                    nxt_tick = '0;
                    if (settle_ff != 8'h00) begin
                        nxt_pwState = hpsc_pkg::PW_WAIT;
                    end
                end
            end
            hpsc_pkg::PW_WAIT: begin
                if (portPowerStart) begin
                    nxt_units = settle_ff;
                    nxt_tick = '0;
                end else if (unitEnd) begin
                    nxt_tick = '0;
                    nxt_units = units_ff - 8'h01;
                    if (units_ff == 8'h01) begin
                        nxt_good = 1'b1;
                        nxt_pwState = hpsc_pkg::PW_IDLE;
                    end
                end else begin
                    nxt_tick = tick_ff + TICK_W'(1);
                end
            end
            default: begin
                nxt_pwState = hpsc_pkg::PW_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pwState_ff <= hpsc_pkg::PW_IDLE;
            tick_ff <= '0;
            units_ff <= 8'h00;
            good_ff <= 1'b0;
        end else begin
            pwState_ff <= nxt_pwState;
            tick_ff <= nxt_tick;
            units_ff <= nxt_units;
            good_ff <= nxt_good;
        end
    end

    // ==========================================
    // string descriptor byte stream
    hpsc_pkg::hpsc_tx_state_t txState_ff, nxt_txState;
    logic [7:0] ptr_ff, nxt_ptr;
    logic [7:0] remain_ff, nxt_remain;
    logic txValid_ff, nxt_txValid;
    logic [7:0] txByte_ff, nxt_txByte;
    logic txLast_ff, nxt_txLast;
    logic txDone_ff, nxt_txDone;
    logic [7:0] selBase;
    logic [7:0] selLen;

    always_comb begin
        selBase = 8'h00;
        selLen = 8'h00;
        case (strSel)
            hpsc_pkg::SEL_MAKER: begin
                selBase = 8'h00;
                selLen = makerLen_ff;
            end
            hpsc_pkg::SEL_ITEM: begin
                selBase = hpsc_pkg::TEXT_AREA_BYTES;
                selLen = itemLen_ff;
            end
            hpsc_pkg::SEL_SERIAL: begin
                selBase = 8'(hpsc_pkg::TEXT_AREA_BYTES << 1);
                selLen = serialLen_ff;
            end
            default: begin
                selBase = 8'h00;
                selLen = 8'h00;
            end
        endcase
    end

    always_comb begin
        nxt_txState = txState_ff;
        nxt_ptr = ptr_ff;
        nxt_remain = remain_ff;
        nxt_txValid = 1'b0;
        nxt_txByte = txByte_ff;
        nxt_txLast = 1'b0;
        nxt_txDone = 1'b0;
        case (txState_ff)
            hpsc_pkg::TX_IDLE: begin
                if (strReq) begin
                    nxt_ptr = selBase;
                    nxt_remain = 8'(selLen << 1);
                    if (selLen == 8'h00) begin
                        nxt_txDone = 1'b1;
                    end else begin
                        nxt_txState = hpsc_pkg::TX_SEND;
                    end
                end
            end
            hpsc_pkg::TX_SEND: begin
                // bytes leave in address order: low byte, then high byte
                nxt_txValid = 1'b1;
                nxt_txByte = textMem[ptr_ff];
                nxt_ptr = ptr_ff + 8'h01;
                nxt_remain = remain_ff - 8'h01;
                if (remain_ff == 8'h01) begin
                    nxt_txLast = 1'b1;
                    nxt_txDone = 1'b1;
                    nxt_txState = hpsc_pkg::TX_IDLE;
                end
            end
            default: begin
                nxt_txState = hpsc_pkg::TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            txState_ff <= hpsc_pkg::TX_IDLE;
            ptr_ff <= 8'h00;
            remain_ff <= 8'h00;
            txValid_ff <= 1'b0;
            txByte_ff <= 8'h00;
            txLast_ff <= 1'b0;
            txDone_ff <= 1'b0;
        end else begin
            txState_ff <= nxt_txState;
            ptr_ff <= nxt_ptr;
            remain_ff <= nxt_remain;
            txValid_ff <= nxt_txValid;
            txByte_ff <= nxt_txByte;
            txLast_ff <= nxt_txLast;
            txDone_ff <= nxt_txDone;
        end
    end

    // ==========================================
    // outputs
    assign cfgRdData = rdData_ff;
    assign cfgRdValid = rdValid_ff;
    assign selfCurrentMa = selfMa_ff;
    assign busCurrentMa = busMa_ff;
    assign languageCode = lang_ff;
    assign portPowerGood = good_ff;
    assign portPowerBusy = pwState_ff[1];
    assign strValid = txValid_ff;
    assign strByte = txByte_ff;
    assign strLast = txLast_ff;
    assign strDone = txDone_ff;
    assign strBusy = txState_ff[1];
endmodule

// *** hpsc_config_bank_assertions.sv ***
`timescale 1ns/100ps
module hpsc_config_bank_assertions (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cfgWrEn,
    input wire logic cfgRdEn,
    input wire logic [7:0] cfgAddr,
    input wire logic [7:0] cfgWrData,
    input wire logic [7:0] cfgRdData,
    input wire logic cfgRdValid,
    input wire logic [8:0] selfCurrentMa,
    input wire logic [8:0] busCurrentMa,
    input wire logic [15:0] languageCode,
    input wire logic portPowerStart,
    input wire logic portPowerGood,
    input wire logic portPowerBusy,
    input wire logic strReq,
    input wire logic strValid,
    input wire logic strLast,
    input wire logic strDone,
    input wire logic strBusy
);
    // ==========================================
    // port relations
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_self_ma; cfgWrEn && cfgAddr == 8'h0e |=> selfCurrentMa == {$past(cfgWrData), 1'b0}; endproperty
    a_self_ma: assert property (p_self_ma) else $error("self current wrong");
    property p_bus_ma; cfgWrEn && cfgAddr == 8'h0f |=> busCurrentMa == {$past(cfgWrData), 1'b0}; endproperty
    a_bus_ma: assert property (p_bus_ma) else $error("bus current wrong");
    property p_self_rst; $fell(rst) |-> selfCurrentMa == 9'h064; endproperty
    a_self_rst: assert property (p_self_rst) else $error("self current reset wrong");
    property p_bus_rst; $fell(rst) |-> busCurrentMa == 9'h064; endproperty
    a_bus_rst: assert property (p_bus_rst) else $error("bus current reset wrong");
    property p_lang_hi; cfgWrEn && cfgAddr == 8'h11 |=> languageCode[15:8] == $past(cfgWrData); endproperty
    a_lang_hi: assert property (p_lang_hi) else $error("language upper wrong");
    property p_lang_lo; cfgWrEn && cfgAddr == 8'h12 |=> languageCode[7:0] == $past(cfgWrData); endproperty
    a_lang_lo: assert property (p_lang_lo) else $error("language lower wrong");
    property p_len; cfgRdEn && cfgAddr inside {8'h13, 8'h14, 8'h15} |=> cfgRdValid && cfgRdData <= 8'h1f; endproperty
    a_len: assert property (p_len) else $error("length above 31");
    property p_settle; portPowerStart |=> portPowerBusy != portPowerGood; endproperty
    a_settle: assert property (p_settle) else $error("settle start wrong");
    property p_str_end; strReq && !strBusy |-> ##[1:64] strDone; endproperty
    a_str_end: assert property (p_str_end) else $error("stream never ends");
    property p_last; strLast |-> strValid && strDone; endproperty
    a_last: assert property (p_last) else $error("last byte unflagged");
    c_str: cover property (strLast);
    c_good: cover property ($rose(portPowerGood));
    c_len: cover property (cfgRdValid && cfgRdData == 8'h1f);
endmodule

bind hpsc_config_bank hpsc_config_bank_assertions u_hpsc_config_bank_assertions (
    .core_clk(core_clk), .rst(rst), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr),
    .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .selfCurrentMa(selfCurrentMa),
    .busCurrentMa(busCurrentMa), .languageCode(languageCode), .portPowerStart(portPowerStart),
    .portPowerGood(portPowerGood), .portPowerBusy(portPowerBusy), .strReq(strReq), .strValid(strValid),
    .strLast(strLast), .strDone(strDone), .strBusy(strBusy)
);

// *** hpsc_cfg_loader.sv ***
`timescale 1ns/100ps
module hpsc_cfg_loader (
    input wire logic core_clk,
    output logic cfgWrEn,
    output logic cfgRdEn,
    output logic [7:0] cfgAddr,
    output logic [7:0] cfgWrData,
    input wire logic [7:0] cfgRdData,
    input wire logic cfgRdValid
);
    // ==========================================
    // byte loader, drives on falling edge
    initial begin
        cfgWrEn = 1'b0;
        cfgRdEn = 1'b0;
        cfgAddr = 8'h00;
        cfgWrData = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        cfgWrEn = 1'b1;
        cfgAddr = a;
        cfgWrData = (a == 8'h0e && d > 8'h32) ? 8'h32 : d;
        @(negedge core_clk);
        cfgWrEn = 1'b0;
        cfgAddr = ~a;
        cfgWrData = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge core_clk);
        cfgRdEn = 1'b1;
        cfgAddr = a;
        @(negedge core_clk);
        // registered valid stands only in the cycle after the strobe; the data holds until the next read
        d = cfgRdData;
        v = cfgRdValid;
        cfgRdEn = 1'b0;
        cfgAddr = ~a;
    endtask
    // length capped, chars low byte then high, ascending
    task automatic loadStr(input logic [7:0] lenA, input logic [7:0] base, input int n);
        wr(lenA, (n > 31) ? 8'h1f : n[7:0]);
        for (int i = 0; i < 2 * n; i++) begin
            wr(base + i[7:0], (base + i[7:0]) ^ 8'h5a);
        end
    endtask
endmodule

// *** hpsc_config_bank_tb.sv ***
`timescale 1ns/100ps
module hpsc_config_bank_tb;
    logic core_clk, rst, cfgWrEn, cfgRdEn, cfgRdValid, portPowerStart, portPowerGood, portPowerBusy;
    logic strReq, strValid, strLast, strDone, strBusy;
    logic [1:0] strSel;
    logic [7:0] cfgAddr, cfgWrData, cfgRdData, strByte;
    logic [8:0] selfCurrentMa, busCurrentMa;
    logic [15:0] languageCode;
    int nFail, nCompared;
    // ==========================================
    // design and loader
    hpsc_config_bank #(.UNIT_CYCLES(4)) u_hpsc_config_bank (.core_clk(core_clk), .rst(rst),
        .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData),
        .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .selfCurrentMa(selfCurrentMa),
        .busCurrentMa(busCurrentMa), .languageCode(languageCode), .portPowerStart(portPowerStart),
        .portPowerGood(portPowerGood), .portPowerBusy(portPowerBusy), .strReq(strReq), .strSel(strSel),
        .strValid(strValid), .strByte(strByte), .strLast(strLast), .strDone(strDone), .strBusy(strBusy));
    hpsc_cfg_loader u_hpsc_cfg_loader (.core_clk(core_clk), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
        .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nFail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", nCompared, nFail);
        if (nFail == 0 && nCompared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        u_hpsc_cfg_loader.rd(a, d, v);
        chk({15'h0, v}, 16'h0001);
        chk({8'h0, d}, {8'h0, e});
    endtask
    // expected byte is the address pattern the loader stored
    task automatic stream(input logic [1:0] sel, input logic [7:0] base, input int n);
        int k;
        int t;
        k = 0;
        @(negedge core_clk);
        strSel = sel;
        strReq = 1'b1;
        @(negedge core_clk);
        strReq = 1'b0;
        // an empty string shows its done pulse in this very cycle
        for (t = 0; t < 80; t++) begin
            if (strValid === 1'b1) begin
                chk({8'h0, strByte}, {8'h0, (base + k[7:0]) ^ 8'h5a});
                chk({15'h0, strLast}, {15'h0, k == 2 * n - 1});
                k++;
            end
            if (strDone === 1'b1) break;
            @(negedge core_clk);
        end
        chk(16'(k), 16'(2 * n));
        if (t == 80) begin
            nFail++;
            end_of_test();
        end
    endtask
    initial begin
        int t;
        rst = 1'b1;
        portPowerStart = 1'b0;
        strReq = 1'b0;
        strSel = 2'h0;
        nFail = 0;
        nCompared = 0;
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        chk({7'h0, selfCurrentMa}, 16'd100);
        chk({7'h0, busCurrentMa}, 16'd100);
        rdChk(8'h0e, 8'h32);
        rdChk(8'h0f, 8'h32);
        rdChk(8'h05, 8'h00);
        rdChk(8'hd0, 8'h00);
        $display("reset test done");
        u_hpsc_cfg_loader.wr(8'h0e, 8'h19);
        chk({7'h0, selfCurrentMa}, 16'd50);
        u_hpsc_cfg_loader.wr(8'h0f, 8'hff);
        chk({7'h0, busCurrentMa}, 16'd510);
        u_hpsc_cfg_loader.wr(8'h0e, 8'h40);
        chk({7'h0, selfCurrentMa}, 16'd100);
        u_hpsc_cfg_loader.wr(8'h11, 8'hab);
        u_hpsc_cfg_loader.wr(8'h12, 8'hcd);
        chk(languageCode, 16'habcd);
        $display("current and language test done");
        u_hpsc_cfg_loader.wr(8'h13, 8'h28);
        rdChk(8'h13, 8'h1f);
        u_hpsc_cfg_loader.wr(8'h15, 8'h20);
        rdChk(8'h15, 8'h1f);
        u_hpsc_cfg_loader.loadStr(8'h13, 8'h16, 31);
        u_hpsc_cfg_loader.loadStr(8'h14, 8'h54, 2);
        u_hpsc_cfg_loader.loadStr(8'h15, 8'h92, 1);
        rdChk(8'h17, 8'h17 ^ 8'h5a);
        stream(2'h0, 8'h16, 31);
        stream(2'h1, 8'h54, 2);
        stream(2'h2, 8'h92, 1);
        stream(2'h3, 8'h00, 0);
        $display("string test done");
        u_hpsc_cfg_loader.wr(8'h10, 8'h02);
        @(negedge core_clk);
        portPowerStart = 1'b1;
        @(negedge core_clk);
        portPowerStart = 1'b0;
        chk({15'h0, portPowerBusy}, 16'h0001);
        // two units of four cycles, counted from the cycle after the start edge
        for (t = 0; t < 100 && portPowerGood !== 1'b1; t++) @(negedge core_clk);
        chk(16'(t), 16'd8);
        chk({15'h0, portPowerBusy}, 16'h0000);
        if (t == 100) end_of_test();
        $display("settle test done");
        end_of_test();
    end
endmodule
